/* File: logic/bsad_pkg.sv */
// package for the packed-byte subtract and sad accumulate datapath
package bsad_pkg;
   localparam int BYTE_W  = 8;
   localparam int HALF_W  = 16;
   localparam int WORD_W  = 32;
   localparam int LANES   = 4;
   localparam int ALIGN_W = 2;
   localparam int DIFF_W  = 9;
   localparam logic [HALF_W-1:0] ACC_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] DEST_RESET = 32'h0000_0000;
   // instruction length class of both operations
   localparam int INSN_LEN_BITS = 32;
   localparam int PARTNER_LEN_BITS = 16;

   typedef enum logic [1:0] {
      BSAD_OP_NONE,
      BSAD_OP_SUB,
      BSAD_OP_SAA
   } bsad_op_t;

   typedef struct packed {
      logic [WORD_W-1:0] hi;
      logic [WORD_W-1:0] lo;
   } bsad_pair_t;

   typedef struct packed {
      bsad_op_t              op;
      logic                  reversePairOrder;
      logic [ALIGN_W-1:0]    alignIndexA;
      logic [ALIGN_W-1:0]    alignIndexB;
      bsad_pair_t            firstSourcePair;
      bsad_pair_t            secondSourcePair;
   } bsad_req_t;

   typedef struct packed {
      logic [WORD_W-1:0] dest0;
      logic [WORD_W-1:0] dest1;
   } bsad_sub_res_t;
endpackage

/* File: logic/bsad_byte_align.sv */
// byte aligner: picks four contiguous bytes from an eight-byte register pair
`timescale 1ns/10ps
module bsad_byte_align (
   input  bsad_pkg::bsad_pair_t                 pairIn,
   input  wire logic                            reversePairOrder,
   input  wire logic [bsad_pkg::ALIGN_W-1:0]    alignIndex,
   output logic      [bsad_pkg::WORD_W-1:0]     aligned
);
   logic [2*bsad_pkg::WORD_W-1:0] pairBytes;

   always_comb begin
      // swap roles so low-order bytes come from the high register
      if (reversePairOrder) begin
         pairBytes = {pairIn.lo, pairIn.hi};
      end else begin
         pairBytes = {pairIn.hi, pairIn.lo};
      end
      aligned = pairBytes[alignIndex*bsad_pkg::BYTE_W +: bsad_pkg::WORD_W];
   end
endmodule // bsad_byte_align

/* File: logic/bsad_datapath.sv */
// packed-byte quad subtract and sum-of-absolute-difference accumulate datapath
// Operation
// - the quad subtract takes each aligned unsigned byte of the second operand from the first.
// - lanes 0,1 go to dest0 and lanes 2,3 to dest1 as sign-extended halves, even lane low.
// - for the subtract, align index a aligns the first pair and index b the second.
// - alignment 00b..11b selects bytes 3..0, 4..1, 5..2, 6..3 of the eight-byte pair.
// - reverse pair order swaps the two registers of each pair before alignment.
// - either operation suppresses misalignment exceptions of parallel 32-bit loads.
// - both operations are decoded as 32-bit encodings.
// - these 32-bit forms may issue together with permitted 16-bit instructions.
// - the accumulate adds the absolute difference of each aligned byte pair into a half.
// - the four sums update both halves of both accumulators independently.
// - accumulator halves wrap modulo 2^16 and never saturate.
// - for the accumulate, index a aligns the first pair and index b the second.
`timescale 1ns/10ps
module bsad_datapath (
   input  wire logic                            clock,
   input  wire logic                            rstn,
   input  wire logic                            issueValid,
   input  bsad_pkg::bsad_req_t                  issueReq,
   input  wire logic                            accClear,
   output bsad_pkg::bsad_sub_res_t              subResult,
   output logic                                 subResultValid,
   output logic      [bsad_pkg::HALF_W-1:0]     acc0LowHalf,
   output logic      [bsad_pkg::HALF_W-1:0]     acc0HighHalf,
   output logic      [bsad_pkg::HALF_W-1:0]     acc1LowHalf,
   output logic      [bsad_pkg::HALF_W-1:0]     acc1HighHalf,
   output logic                                 misalignSuppress,
   output logic                                 wideEncoding,
   output logic                                 pairIssueAllowed
);
   localparam int BW = bsad_pkg::BYTE_W;
   localparam int HW = bsad_pkg::HALF_W;
   localparam int NL = bsad_pkg::LANES;

   logic [bsad_pkg::WORD_W-1:0] alignedA;
   logic [bsad_pkg::WORD_W-1:0] alignedB;
   logic                        isSub;
   logic                        isSaa;
   logic [HW-1:0]               laneDiff [NL];
   logic [HW-1:0]               laneAbs  [NL];
   logic [HW-1:0]               acc_q    [NL];
   logic [HW-1:0]               acc_d    [NL];
   bsad_pkg::bsad_sub_res_t     sub_q;
   bsad_pkg::bsad_sub_res_t     sub_d;
   logic                        subValid_q;
   logic                        subValid_d;

   // decode: only a valid issue carrying a packed-byte op is taken
   always_comb begin
      isSub = 1'b0;
      isSaa = 1'b0;
      if (issueValid) begin
         unique case (issueReq.op)
            bsad_pkg::BSAD_OP_SUB: begin
               isSub = 1'b1;
            end
            bsad_pkg::BSAD_OP_SAA: begin
               isSaa = 1'b1;
            end
            bsad_pkg::BSAD_OP_NONE: begin
               isSub = 1'b0;
            end
            // the spare op code is refused like an idle slot
            default: begin
               isSub = 1'b0;
            end
         endcase
      end
   end

   // both operations share the aligners; the pair operands, pair order and align indices are wired in, not the op
   bsad_byte_align alignFirst (
      .pairIn           (issueReq.firstSourcePair),
      .reversePairOrder (issueReq.reversePairOrder),
      .alignIndex       (issueReq.alignIndexA),
      .aligned          (alignedA)
   );

   bsad_byte_align alignSecond (
      .pairIn           (issueReq.secondSourcePair),
      .reversePairOrder (issueReq.reversePairOrder),
      .alignIndex       (issueReq.alignIndexB),
      .aligned          (alignedB)
   );

   // lane operands: byte i of each aligned word, widened by a zero bit
   logic [bsad_pkg::DIFF_W-1:0] laneOpA [NL];
   logic [bsad_pkg::DIFF_W-1:0] laneOpB [NL];
   logic [bsad_pkg::DIFF_W-1:0] laneD9  [NL];
   logic                        laneNeg [NL];

   always_comb begin
      for (int i = 0; i < NL; i++) begin
         laneOpA[i] = {1'b0, alignedA[i*BW +: BW]};
      end
   end

   always_comb begin
      for (int i = 0; i < NL; i++) begin
         laneOpB[i] = {1'b0, alignedB[i*BW +: BW]};
      end
   end

   // nine bits hold the exact difference of two unsigned bytes, no overflow
   always_comb begin
      for (int i = 0; i < NL; i++) begin
         laneD9[i] = laneOpA[i] - laneOpB[i];
      end
   end

   always_comb begin
      for (int i = 0; i < NL; i++) begin
         laneNeg[i] = laneD9[i][bsad_pkg::DIFF_W-1];
      end
   end

   always_comb begin
      for (int i = 0; i < NL; i++) begin
         laneDiff[i] = {{(HW-bsad_pkg::DIFF_W){laneNeg[i]}}, laneD9[i]};
      end
   end

   // magnitude fits one byte, so negating the widened value is exact
   always_comb begin
      for (int i = 0; i < NL; i++) begin
         if (laneNeg[i]) begin
            laneAbs[i] = HW'(-laneDiff[i]);
         end else begin
            laneAbs[i] = laneDiff[i];
         end
      end
   end

   // subtract result group: dest words only move on a taken subtract
   always_comb begin
      sub_d      = sub_q;
      subValid_d = isSub;
      if (isSub) begin
         sub_d.dest0 = {laneDiff[1], laneDiff[0]};
         sub_d.dest1 = {laneDiff[3], laneDiff[2]};
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sub_q      <= {bsad_pkg::DEST_RESET, bsad_pkg::DEST_RESET};
         subValid_q <= 1'b0;
      end else begin
         sub_q      <= sub_d;
         subValid_q <= subValid_d;
      end
   end

   // accumulator group: clear wins over a same-cycle accumulate
   always_comb begin
      for (int i = 0; i < NL; i++) begin
         acc_d[i] = acc_q[i];
         if (accClear) begin
            acc_d[i] = bsad_pkg::ACC_RESET;
         end else if (isSaa) begin
            // plain modular add: overflow wraps, the sum is never clamped
            acc_d[i] = HW'(acc_q[i] + laneAbs[i]);
         end
      end
   end

   // no overflow flag: keeping blocks small enough is left to software
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NL; i++) begin
            acc_q[i] <= bsad_pkg::ACC_RESET;
         end
      end else begin
         for (int i = 0; i < NL; i++) begin
            acc_q[i] <= acc_d[i];
         end
      end
   end

   // result words straight from their flops
   assign subResult      = sub_q;
   assign subResultValid = subValid_q;

   // lane to accumulator half mapping
   assign acc0LowHalf    = acc_q[0];
   assign acc0HighHalf   = acc_q[1];
   assign acc1LowHalf    = acc_q[2];
   assign acc1HighHalf   = acc_q[3];

   // combinational so the load unit sees it in the issue cycle
   always_comb begin
      misalignSuppress = 1'b0;
      wideEncoding     = 1'b0;
      pairIssueAllowed = 1'b0;
      if (isSub || isSaa) begin
         misalignSuppress = 1'b1;
         wideEncoding     = (bsad_pkg::INSN_LEN_BITS == 32);
      end
      // pairing is only offered for the wide form
      if (wideEncoding) begin
         pairIssueAllowed = (bsad_pkg::PARTNER_LEN_BITS == 16);
      end
   end
endmodule // bsad_datapath

/* File: sim/bsad_issue_model.sv */
// issue-side model: hands one packed-byte request per clock to the datapath
`timescale 1ns/10ps
module bsad_issue_model (
   input  wire logic          clock,
   output logic               issueValid,
   output bsad_pkg::bsad_req_t issueReq
);
   initial begin
      issueValid = 1'b0;
      issueReq = '0;
   end
   // only the two legal pairs exist as operand fields, so no other pair can be named
   task automatic send(bsad_pkg::bsad_req_t q);
      @(posedge clock);
      issueValid <= 1'b1;
      issueReq <= q;
   endtask
   // released operands flip so stale data never passes for a request
   task automatic idle;
      @(posedge clock);
      issueValid <= 1'b0;
      issueReq <= ~issueReq;
   endtask
endmodule // bsad_issue_model

/* File: sim/bsad_datapath_asserts.sv */
// assertion checker bound to the packed-byte datapath
`timescale 1ns/10ps
module bsad_datapath_asserts (
   input wire logic clock, rstn, issueValid, accClear, subResultValid,
   input bsad_pkg::bsad_req_t issueReq,
   input bsad_pkg::bsad_sub_res_t subResult,
   input wire logic [15:0] acc0LowHalf, acc0HighHalf, acc1LowHalf, acc1HighHalf,
   input wire logic misalignSuppress, wideEncoding, pairIssueAllowed
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   wire sub = issueValid && issueReq.op == bsad_pkg::BSAD_OP_SUB;
   wire wide = sub || issueValid && issueReq.op == bsad_pkg::BSAD_OP_SAA;
   wire [63:0] acc = {acc1HighHalf, acc1LowHalf, acc0HighHalf, acc0LowHalf};
   property p_valid; sub |=> subResultValid; endproperty
   a_valid: assert property (p_valid) else $error("missing result");
   property p_quiet; !sub |=> !subResultValid && $stable(subResult); endproperty
   a_quiet: assert property (p_quiet) else $error("spurious result");
   property p_sign; subResultValid |-> subResult.dest1[31:24] == {8{subResult.dest1[24]}}; endproperty
   a_sign: assert property (p_sign) else $error("bad sign extension");
   property p_supp; misalignSuppress == wide; endproperty
   a_supp: assert property (p_supp) else $error("bad suppress");
   property p_wide; wideEncoding == wide; endproperty
   a_wide: assert property (p_wide) else $error("bad length class");
   property p_pair; pairIssueAllowed == wideEncoding; endproperty
   a_pair: assert property (p_pair) else $error("bad pairing flag");
   property p_clear; accClear |=> acc == 64'h0; endproperty
   a_clear: assert property (p_clear) else $error("clear failed");
   property p_hold; !accClear && !(wide && !sub) |=> $stable(acc); endproperty
   a_hold: assert property (p_hold) else $error("acc moved");
endmodule // bsad_datapath_asserts
bind bsad_datapath bsad_datapath_asserts i_bsad_datapath_asserts (.*);

/* File: sim/tb_top.sv */
// self-checking bench for the packed-byte datapath
`timescale 1ns/10ps
module tb_top;
   logic clock, rstn, accClear, issueValid, subResultValid;
   logic misalignSuppress, wideEncoding, pairIssueAllowed;
   logic [15:0] acc0L, acc0H, acc1L, acc1H;
   bsad_pkg::bsad_req_t issueReq, r;
   bsad_pkg::bsad_sub_res_t subResult;
   int errors, compares;
   bsad_issue_model i_bsad_issue_model (.clock(clock), .issueValid(issueValid),
      .issueReq(issueReq));
   bsad_datapath i_bsad_datapath (.clock(clock), .rstn(rstn), .issueValid(issueValid),
      .issueReq(issueReq), .accClear(accClear), .subResult(subResult),
      .subResultValid(subResultValid), .acc0LowHalf(acc0L), .acc0HighHalf(acc0H),
      .acc1LowHalf(acc1L), .acc1HighHalf(acc1H), .misalignSuppress(misalignSuppress),
      .wideEncoding(wideEncoding), .pairIssueAllowed(pairIssueAllowed));
   function automatic logic [31:0] al(bsad_pkg::bsad_pair_t p, logic rv, logic [1:0] x);
      logic [63:0] w;
      w = rv ? {p.lo, p.hi} : {p.hi, p.lo};
      return w[x*8+:32];
   endfunction
   task automatic chk(string n, logic [63:0] e, logic [63:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // back-to-back subtracts over every alignment and both pair orders
   task automatic sub_test;
      logic [31:0] x, y;
      logic [8:0] d;
      logic [63:0] p;
      r = '0;
      r.op = bsad_pkg::BSAD_OP_SUB;
      {r.firstSourcePair, r.secondSourcePair} = {64'h0081020304f5f607, 64'h80fe02fc7f01f903};
      for (int k = 0; k < 32; k++) begin
         {r.reversePairOrder, r.alignIndexA, r.alignIndexB} = k[4:0];
         i_bsad_issue_model.send(r);
         #1 chk("flags", {k > 0, 3'b111}, {subResultValid, misalignSuppress, wideEncoding,
            pairIssueAllowed});
         if (k > 0) chk("sub", p, {subResult.dest1, subResult.dest0});
         x = al(r.firstSourcePair, r.reversePairOrder, r.alignIndexA);
         y = al(r.secondSourcePair, r.reversePairOrder, r.alignIndexB);
         for (int i = 0; i < 4; i++) begin
            d = {1'b0, x[i*8+:8]} - {1'b0, y[i*8+:8]};
            p[i*16+:16] = {{7{d[8]}}, d};
         end
      end
      i_bsad_issue_model.idle;
      #1 chk("sub", p, {subResult.dest1, subResult.dest0});
   endtask
   // long run wraps the halves; a second call proves the clear
   task automatic saa_test(int n);
      logic [31:0] x, y;
      logic [15:0] s [4];
      s = '{default: 16'h0000};
      @(posedge clock) accClear <= 1'b1;
      @(posedge clock) accClear <= 1'b0;
      r.op = bsad_pkg::BSAD_OP_SAA;
      {r.firstSourcePair, r.secondSourcePair} = {64'hfffefdfcfbfaf9f8, 64'h0001020304050607};
      for (int k = 0; k < n; k++) begin
         {r.reversePairOrder, r.alignIndexA, r.alignIndexB} = k[4:0];
         x = al(r.firstSourcePair, r.reversePairOrder, r.alignIndexA);
         y = al(r.secondSourcePair, r.reversePairOrder, r.alignIndexB);
         for (int i = 0; i < 4; i++)
            s[i] += (x[i*8+:8] > y[i*8+:8]) ? x[i*8+:8] - y[i*8+:8] : y[i*8+:8] - x[i*8+:8];
         i_bsad_issue_model.send(r);
      end
      r.op = bsad_pkg::BSAD_OP_NONE;
      i_bsad_issue_model.send(r);
      #1 chk("refused", 0, {misalignSuppress, wideEncoding, pairIssueAllowed});
      i_bsad_issue_model.idle;
      #1 chk("acc", {s[3], s[2], s[1], s[0]}, {acc1H, acc1L, acc0H, acc0L});
   endtask
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      rstn = 1'b0;
      accClear = 1'b0;
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      sub_test;
      saa_test(300);
      saa_test(256);
      report_and_stop;
   end
endmodule // tb_top
